/* rtl/dsp_seq_regs.svh */
// Register indices, field positions, reset values and counts of the sequencer
// What this block does
// - Parameter and data words are signed 5.23, spanning -16.0 to +16.0-1LSB.
// - 24-bit serial input samples are sign-extended into the 28-bit core word.
// - Outputs saturate the top four bits to a 24-bit value within +-1.0.
// - Normal rate gives 3584 instruction cycles per sample, whole program per frame.
// - Double- and quad-speed modes, picked by a core setting, cut the budget.
// - The per-frame limit is 1792 at double rate and 896 at quad rate.
// - Each frame start restarts the program counter, which then steps by one unless a valid branch loads its address.
// - Jump-to-start loads 0x2010 and holds there until the next frame.
// - Frame start before returning to start marks audio corrupt until reset.
// - Core run bit 0 resets to 0; setting it starts program execution.
// - Clearing core run ramps the serial output samples down to zero.
// - Checksum enable is bit 0 of the third group register, reset 0.
// - While enabled, every 4096 frames compute a 32-bit checksum and compare.
// - A mismatch raises an error flag, reaching the pin only when selected.
// - The error stays until the enable goes low, which clears it.
// - The error is a read-only sticky bit 0 at 0xE225, reset 0.
// - Bit 1 of the error-mute control mutes the core on checksum error.
`ifndef DSP_SEQ_REGS_SVH
`define DSP_SEQ_REGS_SVH

`define IDX_CKSUM_HI   16'he200
`define IDX_CKSUM_LO   16'he201
`define IDX_CKSUM_EN   16'he202
`define IDX_MP_SEL     16'he204
`define IDX_CORE_RATE  16'he220
`define IDX_CKSUM_ERR  16'he225
`define IDX_ERR_MUTE   16'he227
`define IDX_CORE_RUN   16'he228
`define IDX_PC_PEAK    16'he229
`define IDX_SEQ_STAT   16'he22a

`define REG_RESET      16'h0000
`define BIT_RUN        0
`define BIT_CKSUM_EN   0
`define BIT_ERR_STICKY 0
`define BIT_MUTE_CRC   1
`define BIT_MP_CRC     0

`define PROG_START     14'h2010
`define LIMIT_NORMAL   12'he00
`define LIMIT_DOUBLE   12'h700
`define LIMIT_QUAD     12'h380
`define CRC_FRAME_LAST 12'hfff
`define CRC_WORD_LAST  12'hfff
`define CRC_POLY       32'h04c11db7
`define CRC_INIT       32'hffffffff
`define CRC_XOROUT     32'hffffffff
`define SLEW_STEP      24'h000800

`define RESP_OKAY      2'b00
`define RESP_SLVERR    2'b10

`endif

/* rtl/dsp_seq_pkg.sv */
// Types shared by the core sequencer files
package dsp_seq_pkg;

  typedef enum logic [1:0] {
    RATE_NORMAL = 2'h0,
    RATE_DOUBLE = 2'h1,
    RATE_QUAD   = 2'h2
  } core_rate_type;

  typedef enum {SEQ_HALT, SEQ_WAIT, SEQ_EXEC} seq_state_type;

  typedef enum {SCAN_IDLE, SCAN_FILL, SCAN_RUN, SCAN_CHECK} scan_state_type;

  typedef struct packed {
    logic [15:0] exp_hi;
    logic [15:0] exp_lo;
    logic        en;
    logic        mp_crc;
    logic [1:0]  rate;
    logic [1:0]  err_mute;
    logic        run;
  } ctrl_regs_type;

  typedef struct packed {
    logic        valid;
    logic [13:0] addr;
  } branch_type;

endpackage

/* rtl/crc_step.sv */
// One CRC-32 update over a full program word, most significant bit first
`timescale 1ns/1ns
`include "dsp_seq_regs.svh"
module crc_step #(
  parameter int DW = 43
) (
  input  wire logic [31:0]   i_crc,
  input  wire logic [DW-1:0] i_data,
  output logic      [31:0]   o_crc
);
  always_comb begin
    logic [31:0] c;
    logic        fb;
    c  = i_crc;
    fb = 1'b0;
    for (int i = DW - 1; i >= 0; i--) begin
      fb = c[31] ^ i_data[i];
      c  = {c[30:0], 1'b0} ^ (fb ? `CRC_POLY : 32'h0);
    end
    o_crc = c;
  end
endmodule

/* rtl/out_conditioner.sv */
// Output clipper and slew-to-zero stage for one serial output channel
`timescale 1ns/1ns
`include "dsp_seq_regs.svh"
module out_conditioner #(
  parameter int              CW   = 28,
  parameter int              OW   = 24,
  parameter logic [OW-1:0]   STEP = `SLEW_STEP
) (
  input  wire logic          i_clk,
  input  wire logic          i_rst,
  input  wire logic [CW-1:0] i_sample,
  input  wire logic          i_step,
  input  wire logic          i_mute,
  output logic      [OW-1:0] o_sample
);
  logic [CW-OW:0] top;
  logic [OW-1:0]  clip;
  logic [OW-1:0]  mag;

  assign top = i_sample[CW-1:OW-1];
  assign mag = OW'(-o_sample);

  always_comb begin
    if (&top || ~|top) begin
      clip = i_sample[OW-1:0];
    end else if (i_sample[CW-1]) begin
      clip = {1'b1, {(OW-1){1'b0}}};
    end else begin
      clip = {1'b0, {(OW-1){1'b1}}};
    end
  end

  // Muted output walks toward zero one step per frame, never overshooting
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_sample <= '0;
    end else if (!i_mute) begin
      o_sample <= clip;
    end else if (i_step) begin
      if (o_sample[OW-1]) begin
        o_sample <= (mag <= STEP) ? '0 : o_sample + STEP;
      end else begin
        o_sample <= (o_sample <= STEP) ? '0 : o_sample - STEP;
      end
    end
  end
endmodule

/* rtl/dsp_core_sequencer.sv */
// Core sequencer, checksum scanner, sample formatting and register slave
`timescale 1ns/1ns
`include "dsp_seq_regs.svh"
module dsp_core_sequencer
  import dsp_seq_pkg::*;
#(
  parameter int AW = 18,
  parameter int PW = 43
) (
  input  wire logic          i_clk,
  input  wire logic          i_rst,
  input  wire logic          i_awvalid,
  output logic               o_awready,
  input  wire logic [AW-1:0] i_awaddr,
  input  wire logic          i_wvalid,
  output logic               o_wready,
  input  wire logic [31:0]   i_wdata,
  input  wire logic [3:0]    i_wstrb,
  output logic               o_bvalid,
  input  wire logic          i_bready,
  output logic [1:0]         o_bresp,
  input  wire logic          i_arvalid,
  output logic               o_arready,
  input  wire logic [AW-1:0] i_araddr,
  output logic               o_rvalid,
  input  wire logic          i_rready,
  output logic [31:0]        o_rdata,
  output logic [1:0]         o_rresp,
  input  wire logic          i_frame_start,
  input  wire logic          i_jump_to_start,
  input  wire branch_type    i_branch,
  input  wire logic [23:0]   i_in_sample,
  input  wire logic [27:0]   i_core_out,
  input  wire logic [PW-1:0] i_prog_word,
  output logic [13:0]        o_pc,
  output logic               o_core_run,
  output logic [27:0]        o_core_in,
  output logic [23:0]        o_out_sample,
  output logic [11:0]        o_prog_addr,
  output logic               o_multipurpose_output_pin
);
  ctrl_regs_type  ctrl_r;
  seq_state_type  state_r;
  scan_state_type scan_r;
  logic           aw_held_r;
  logic           w_held_r;
  logic [15:0]    aw_idx_r;
  logic [31:0]    w_data_r;
  logic [3:0]     w_strb_r;
  logic           aw_held_nxt;
  logic           w_held_nxt;
  logic           do_write;
  logic           take_ar;
  logic           rvalid_nxt;
  logic           mapped_w;
  logic [31:0]    rd_word;
  logic           rd_ok;
  logic [11:0]    cnt_r;
  logic [11:0]    limit;
  logic [15:0]    peak_r;
  logic           corrupt_r;
  logic           err_r;
  logic [11:0]    frame_cnt_r;
  logic [11:0]    words_r;
  logic [31:0]    crc_r;
  logic [31:0]    crc_nxt;
  logic           mismatch;
  logic           mute;
  logic [15:0]    m;

  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0]  s);
    merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // Write address and data are taken in either order, one write at a time
  assign do_write    = aw_held_r && w_held_r && !o_bvalid;
  assign aw_held_nxt = (aw_held_r && !do_write) || (o_awready && i_awvalid);
  assign w_held_nxt  = (w_held_r && !do_write) || (o_wready && i_wvalid);
  assign take_ar     = o_arready && i_arvalid;
  assign rvalid_nxt  = take_ar || (o_rvalid && !i_rready);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      o_awready <= 1'b0;
      o_wready  <= 1'b0;
      aw_idx_r  <= '0;
      w_data_r  <= '0;
      w_strb_r  <= '0;
    end else begin
      aw_held_r <= aw_held_nxt;
      w_held_r  <= w_held_nxt;
      o_awready <= !aw_held_nxt;
      o_wready  <= !w_held_nxt;
      if (o_awready && i_awvalid) begin
        aw_idx_r <= i_awaddr[AW-1:2];
      end
      if (o_wready && i_wvalid) begin
        w_data_r <= i_wdata;
        w_strb_r <= i_wstrb;
      end
    end
  end

  always_comb begin
    case (aw_idx_r)
      `IDX_CKSUM_HI, `IDX_CKSUM_LO, `IDX_CKSUM_EN, `IDX_MP_SEL,
      `IDX_CORE_RATE, `IDX_CKSUM_ERR, `IDX_ERR_MUTE, `IDX_CORE_RUN,
      `IDX_PC_PEAK, `IDX_SEQ_STAT: mapped_w = 1'b1;
      default: mapped_w = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_bvalid <= 1'b0;
      o_bresp  <= `RESP_OKAY;
    end else if (do_write) begin
      o_bvalid <= 1'b1;
      o_bresp  <= mapped_w ? `RESP_OKAY : `RESP_SLVERR;
    end else if (i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  // Control registers; status registers ignore writes
  assign m = merge(`REG_RESET, w_data_r, w_strb_r);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctrl_r <= '0;
    end else if (do_write) begin
      case (aw_idx_r)
        `IDX_CKSUM_HI: ctrl_r.exp_hi <= merge(ctrl_r.exp_hi, w_data_r,
                                              w_strb_r);
        `IDX_CKSUM_LO: ctrl_r.exp_lo <= merge(ctrl_r.exp_lo, w_data_r,
                                              w_strb_r);
        `IDX_CKSUM_EN: if (w_strb_r[0]) ctrl_r.en <= m[`BIT_CKSUM_EN];
        `IDX_MP_SEL: if (w_strb_r[0]) ctrl_r.mp_crc <= m[`BIT_MP_CRC];
        `IDX_CORE_RATE: if (w_strb_r[0]) ctrl_r.rate <= m[1:0];
        `IDX_ERR_MUTE: if (w_strb_r[0]) ctrl_r.err_mute <= m[1:0];
        `IDX_CORE_RUN: if (w_strb_r[0]) ctrl_r.run <= m[`BIT_RUN];
        default: ctrl_r <= ctrl_r;
      endcase
    end
  end

  always_comb begin
    rd_word = 32'h0;
    rd_ok   = 1'b1;
    case (i_araddr[AW-1:2])
      `IDX_CKSUM_HI:  rd_word[15:0] = ctrl_r.exp_hi;
      `IDX_CKSUM_LO:  rd_word[15:0] = ctrl_r.exp_lo;
      `IDX_CKSUM_EN:  rd_word[`BIT_CKSUM_EN] = ctrl_r.en;
      `IDX_MP_SEL:    rd_word[`BIT_MP_CRC] = ctrl_r.mp_crc;
      `IDX_CORE_RATE: rd_word[1:0] = ctrl_r.rate;
      `IDX_CKSUM_ERR: rd_word[`BIT_ERR_STICKY] = err_r;
      `IDX_ERR_MUTE:  rd_word[1:0] = ctrl_r.err_mute;
      `IDX_CORE_RUN:  rd_word[`BIT_RUN] = ctrl_r.run;
      `IDX_PC_PEAK:   rd_word[15:0] = peak_r;
      `IDX_SEQ_STAT:  rd_word[2:0] = {scan_r != SCAN_IDLE,
                                      state_r == SEQ_EXEC, corrupt_r};
      default:        rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rvalid  <= 1'b0;
      o_arready <= 1'b0;
      o_rdata   <= '0;
      o_rresp   <= `RESP_OKAY;
    end else begin
      o_rvalid  <= rvalid_nxt;
      o_arready <= !rvalid_nxt;
      if (take_ar) begin
        o_rdata <= rd_word;
        o_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
    end
  end

  always_comb begin
    case (ctrl_r.rate)
      RATE_DOUBLE: limit = `LIMIT_DOUBLE;
      RATE_QUAD:   limit = `LIMIT_QUAD;
      default:     limit = `LIMIT_NORMAL;
    endcase
  end

  // Program counter: one instruction per clock from the start address
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_r <= SEQ_HALT;
      o_pc    <= `PROG_START;
      cnt_r   <= '0;
      peak_r  <= '0;
    end else begin
      case (state_r)
        SEQ_HALT: begin
          o_pc <= `PROG_START;
          if (ctrl_r.run) state_r <= SEQ_WAIT;
        end
        SEQ_WAIT: begin
          if (!ctrl_r.run) begin
            state_r <= SEQ_HALT;
          end else if (i_frame_start) begin
            state_r <= SEQ_EXEC;
            cnt_r   <= '0;
          end
        end
        SEQ_EXEC: begin
          if (!ctrl_r.run) begin
            state_r <= SEQ_HALT;
            o_pc    <= `PROG_START;
          end else if (i_frame_start) begin
            o_pc  <= `PROG_START;
            cnt_r <= '0;
          end else if (i_jump_to_start || cnt_r == limit - 12'h1) begin
            o_pc    <= `PROG_START;
            state_r <= SEQ_WAIT;
            peak_r  <= {4'h0, cnt_r} + 16'h1;
          end else begin
            o_pc  <= i_branch.valid ? i_branch.addr : o_pc + 14'h1;
            cnt_r <= cnt_r + 12'h1;
          end
        end
        default: state_r <= SEQ_HALT;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      corrupt_r <= 1'b0;
    end else if (state_r == SEQ_EXEC && ctrl_r.run && i_frame_start) begin
      corrupt_r <= 1'b1;
    end
  end

  // Periodic program memory scan, one word per clock, ascending
  crc_step #(.DW(PW)) i_crc_step (
    .i_crc  (crc_r),
    .i_data (i_prog_word),
    .o_crc  (crc_nxt)
  );

  assign mismatch = (crc_r ^ `CRC_XOROUT) != {ctrl_r.exp_hi, ctrl_r.exp_lo};

  always_ff @(posedge i_clk) begin
    if (i_rst || !ctrl_r.en) begin
      frame_cnt_r <= '0;
    end else if (i_frame_start) begin
      frame_cnt_r <= frame_cnt_r + 12'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || !ctrl_r.en) begin
      scan_r      <= SCAN_IDLE;
      o_prog_addr <= '0;
      words_r     <= '0;
      crc_r       <= `CRC_INIT;
    end else begin
      case (scan_r)
        SCAN_IDLE: begin
          if (i_frame_start && frame_cnt_r == `CRC_FRAME_LAST) begin
            scan_r      <= SCAN_FILL;
            o_prog_addr <= '0;
            words_r     <= '0;
            crc_r       <= `CRC_INIT;
          end
        end
        SCAN_FILL: begin
          scan_r      <= SCAN_RUN;
          o_prog_addr <= 12'h1;
        end
        SCAN_RUN: begin
          crc_r       <= crc_nxt;
          o_prog_addr <= o_prog_addr + 12'h1;
          words_r     <= words_r + 12'h1;
          if (words_r == `CRC_WORD_LAST) scan_r <= SCAN_CHECK;
        end
        SCAN_CHECK: scan_r <= SCAN_IDLE;
        default:    scan_r <= SCAN_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || !ctrl_r.en) begin
      err_r <= 1'b0;
    end else if (scan_r == SCAN_CHECK && mismatch) begin
      err_r <= 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_multipurpose_output_pin   <= 1'b0;
      o_core_run <= 1'b0;
      o_core_in  <= '0;
    end else begin
      o_multipurpose_output_pin   <= err_r && ctrl_r.mp_crc;
      o_core_run <= ctrl_r.run;
      o_core_in  <= {{4{i_in_sample[23]}}, i_in_sample};
    end
  end

  assign mute = !ctrl_r.run || corrupt_r ||
                (ctrl_r.err_mute[`BIT_MUTE_CRC] && err_r);

  out_conditioner #(.CW(28), .OW(24)) i_out_conditioner (
    .i_clk    (i_clk),
    .i_rst    (i_rst),
    .i_sample (i_core_out),
    .i_step   (i_frame_start),
    .i_mute   (mute),
    .o_sample (o_out_sample)
  );

  property p_halt_pc;
    @(posedge i_clk) disable iff (i_rst)
      (state_r == SEQ_HALT) |=> (o_pc == `PROG_START);
  endproperty
  a_halt_pc: assert property (p_halt_pc)
    else $error("PC left start while halted");

  property p_jump;
    @(posedge i_clk) disable iff (i_rst)
      (state_r == SEQ_EXEC && ctrl_r.run && !i_frame_start &&
       i_jump_to_start) |=> (o_pc == `PROG_START && state_r == SEQ_WAIT);
  endproperty
  a_jump: assert property (p_jump)
    else $error("jump did not park PC at start");

  property p_wait_hold;
    @(posedge i_clk) disable iff (i_rst)
      (state_r == SEQ_WAIT) ##1 (state_r == SEQ_WAIT) |->
        (o_pc == `PROG_START && $stable(o_pc));
  endproperty
  a_wait_hold: assert property (p_wait_hold)
    else $error("PC moved while waiting for frame");

  property p_budget;
    @(posedge i_clk) disable iff (i_rst)
      (state_r == SEQ_EXEC) |-> (cnt_r < limit);
  endproperty
  a_budget: assert property (p_budget)
    else $error("instruction budget exceeded");

  property p_corrupt;
    @(posedge i_clk) disable iff (i_rst)
      (state_r == SEQ_EXEC && ctrl_r.run && i_frame_start) |=>
        corrupt_r [*3];
  endproperty
  a_corrupt: assert property (p_corrupt)
    else $error("early frame not flagged corrupt");

  property p_err_clear;
    @(posedge i_clk) disable iff (i_rst)
      $fell(ctrl_r.en) |=> !err_r ##1 !o_multipurpose_output_pin;
  endproperty
  a_err_clear: assert property (p_err_clear)
    else $error("error survived enable clear");

  property p_err_sticky;
    @(posedge i_clk) disable iff (i_rst)
      (err_r && ctrl_r.en) ##1 ctrl_r.en |-> err_r;
  endproperty
  a_err_sticky: assert property (p_err_sticky)
    else $error("error dropped while enabled");

  property p_err_set;
    @(posedge i_clk) disable iff (i_rst)
      (scan_r == SCAN_CHECK && mismatch && ctrl_r.en) |=>
        err_r ##1 (o_multipurpose_output_pin == ctrl_r.mp_crc);
  endproperty
  a_err_set: assert property (p_err_set)
    else $error("mismatch not reported");

  property p_run_halt;
    @(posedge i_clk) disable iff (i_rst)
      $fell(ctrl_r.run) |=> (state_r == SEQ_HALT && !o_core_run);
  endproperty
  a_run_halt: assert property (p_run_halt)
    else $error("core kept running after run cleared");
endmodule

/* sim/dsp_core_sequencer_tb.sv */
// Self-checking testbench for the core sequencer and its register slave
`timescale 1ns/1ns
`include "dsp_seq_regs.svh"
module dsp_core_sequencer_tb
  import dsp_seq_pkg::*;
;
  localparam int LIMIT = 80000;
  localparam int LIMS [3] = '{3584, 1792, 896};

  logic        i_clk           = 1'b0;
  logic        i_rst           = 1'b1;
  logic        i_awvalid       = 1'b0;
  logic [17:0] i_awaddr        = '0;
  logic        i_wvalid        = 1'b0;
  logic [31:0] i_wdata         = '0;
  logic [3:0]  i_wstrb         = '0;
  logic        i_bready        = 1'b0;
  logic        i_arvalid       = 1'b0;
  logic [17:0] i_araddr        = '0;
  logic        i_rready        = 1'b0;
  logic        i_frame_start   = 1'b0;
  logic        i_jump_to_start = 1'b0;
  branch_type  i_branch        = '0;
  logic [23:0] i_in_sample     = '0;
  logic [27:0] i_core_out      = '0;
  logic [42:0] i_prog_word     = '0;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic        o_core_run, o_multipurpose_output_pin;
  logic [1:0]  o_bresp, o_rresp;
  logic [31:0] o_rdata;
  logic [13:0] o_pc;
  logic [27:0] o_core_in;
  logic [23:0] o_out_sample;
  logic [11:0] o_prog_addr;
  int          num_errors = 0;
  int          cmp_count  = 0;
  int          cycles     = 0;
  int          n;
  logic [1:0]  resp;
  logic [31:0] rd;
  logic [31:0] good_crc;
  logic [23:0] sx [4] = '{24'h7fffff, 24'h800000, 24'h123456, 24'hffffff};
  logic [27:0] cv [5] = '{28'h0100000, 28'h0800000, 28'hf7fffff,
                          28'hfffffff, 28'h07fffff};
  logic [15:0] rv [6] = '{`IDX_CKSUM_HI, `IDX_CKSUM_LO, `IDX_CKSUM_EN,
                          `IDX_CKSUM_ERR, `IDX_ERR_MUTE, `IDX_CORE_RUN};

  dsp_core_sequencer i_dsp_core_sequencer (
    .i_clk(i_clk), .i_rst(i_rst), .i_awvalid(i_awvalid),
    .o_awready(o_awready), .i_awaddr(i_awaddr), .i_wvalid(i_wvalid),
    .o_wready(o_wready), .i_wdata(i_wdata), .i_wstrb(i_wstrb),
    .o_bvalid(o_bvalid), .i_bready(i_bready), .o_bresp(o_bresp),
    .i_arvalid(i_arvalid), .o_arready(o_arready), .i_araddr(i_araddr),
    .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata),
    .o_rresp(o_rresp), .i_frame_start(i_frame_start),
    .i_jump_to_start(i_jump_to_start), .i_branch(i_branch),
    .i_in_sample(i_in_sample), .i_core_out(i_core_out),
    .i_prog_word(i_prog_word), .o_pc(o_pc), .o_core_run(o_core_run),
    .o_core_in(o_core_in), .o_out_sample(o_out_sample),
    .o_prog_addr(o_prog_addr), .o_multipurpose_output_pin(o_multipurpose_output_pin)
  );

  always #5 i_clk = ~i_clk;

  function automatic logic [42:0] prog_word(input logic [11:0] a);
    return {a, ~a, a, 7'h15};
  endfunction

  function automatic logic [31:0] crc_all();
    logic [31:0] c;
    logic [42:0] w;
    c = `CRC_INIT;
    for (int a = 0; a < 4096; a++) begin
      w = prog_word(12'(a));
      for (int b = 42; b >= 0; b--) begin
        c = {c[30:0], 1'b0} ^ ((c[31] ^ w[b]) ? `CRC_POLY : 32'h0);
      end
    end
    return c ^ `CRC_XOROUT;
  endfunction

  function automatic logic [23:0] clip(input logic [27:0] v);
    if (v[27:23] == 5'h00 || v[27:23] == 5'h1f) begin
      return v[23:0];
    end
    return v[27] ? 24'h800000 : 24'h7fffff;
  endfunction

  // Program RAM answers one cycle after the address
  always @(posedge i_clk) i_prog_word <= prog_word(o_prog_addr);

  task automatic conclude();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  always @(posedge i_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      num_errors++;
      conclude();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic axi_write(input logic [15:0] idx, input logic [31:0] d);
    logic aw_ok, w_ok, b_ok;
    @(posedge i_clk);
    i_awvalid <= 1'b1;
    i_awaddr  <= {idx, 2'b00};
    i_wvalid  <= 1'b1;
    i_wdata   <= d;
    i_wstrb   <= 4'hf;
    i_bready  <= 1'b1;
    aw_ok = 1'b0;
    w_ok  = 1'b0;
    b_ok  = 1'b0;
    while (!b_ok) begin
      @(posedge i_clk);
      if (!aw_ok && o_awready === 1'b1) begin
        aw_ok = 1'b1;
        i_awvalid <= 1'b0;
      end
      if (!w_ok && o_wready === 1'b1) begin
        w_ok = 1'b1;
        i_wvalid <= 1'b0;
      end
      if (o_bvalid === 1'b1) begin
        b_ok = 1'b1;
        resp = o_bresp;
        i_bready <= 1'b0;
      end
    end
  endtask

  task automatic axi_read(input logic [15:0] idx);
    logic ar_ok, r_ok;
    @(posedge i_clk);
    i_arvalid <= 1'b1;
    i_araddr  <= {idx, 2'b00};
    i_rready  <= 1'b1;
    ar_ok = 1'b0;
    r_ok  = 1'b0;
    while (!r_ok) begin
      @(posedge i_clk);
      if (!ar_ok && o_arready === 1'b1) begin
        ar_ok = 1'b1;
        i_arvalid <= 1'b0;
      end
      if (o_rvalid === 1'b1) begin
        r_ok = 1'b1;
        rd   = o_rdata;
        resp = o_rresp;
        i_rready <= 1'b0;
      end
    end
  endtask

  task automatic expect_reg(input logic [15:0] idx, input logic [31:0] exp);
    axi_read(idx);
    check(32'(resp), 32'(`RESP_OKAY));
    check(rd, exp);
  endtask

  task automatic frame();
    @(posedge i_clk) i_frame_start <= 1'b1;
    @(posedge i_clk) i_frame_start <= 1'b0;
  endtask

  task automatic count_off_start(input int len);
    n = 0;
    repeat (len) begin
      @(negedge i_clk);
      if (o_pc !== `PROG_START) n++;
    end
  endtask

  task automatic do_reset();
    @(posedge i_clk) i_rst <= 1'b1;
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
  endtask

  // Reference checksum written first, enable last, then a full 4096-frame period
  task automatic crc_round(input logic [31:0] ref_crc);
    axi_write(`IDX_CKSUM_HI, {16'h0, ref_crc[31:16]});
    axi_write(`IDX_CKSUM_LO, {16'h0, ref_crc[15:0]});
    axi_write(`IDX_CKSUM_EN, 32'h1);
    repeat (4096) begin
      frame();
      repeat (2) @(posedge i_clk);
    end
    repeat (4200) @(posedge i_clk);
  endtask

  initial begin
    good_crc = crc_all();
    do_reset();
    foreach (rv[k]) expect_reg(rv[k], 32'h0);
    axi_write(`IDX_CKSUM_HI, 32'h1234);
    expect_reg(`IDX_CKSUM_HI, 32'h1234);
    axi_write(`IDX_CKSUM_LO, 32'habcd);
    expect_reg(`IDX_CKSUM_LO, 32'habcd);
    axi_write(`IDX_CKSUM_ERR, 32'h1);
    check(32'(resp), 32'(`RESP_OKAY));
    expect_reg(`IDX_CKSUM_ERR, 32'h0);
    axi_read(16'he2ff);
    check(32'(resp), 32'(`RESP_SLVERR));
    axi_write(16'he2ff, 32'h1);
    check(32'(resp), 32'(`RESP_SLVERR));
    foreach (sx[k]) begin
      @(posedge i_clk) i_in_sample <= sx[k];
      @(posedge i_clk);
      @(negedge i_clk);
      check(32'(o_core_in), {8'h0, {4{sx[k][23]}}, sx[k]});
    end
    frame();
    count_off_start(20);
    check(32'(n), 32'h0);
    check(32'(o_core_run), 32'h0);
    axi_write(`IDX_CORE_RUN, 32'h1);
    @(posedge i_clk);
    @(negedge i_clk);
    check(32'(o_core_run), 32'h1);
    for (int r = 0; r < 3; r++) begin
      axi_write(`IDX_CORE_RATE, 32'(r));
      frame();
      count_off_start(LIMS[r] + 20);
      check(32'(n), 32'(LIMS[r] - 1));
      expect_reg(`IDX_PC_PEAK, 32'(LIMS[r]));
    end
    axi_write(`IDX_CORE_RATE, 32'h0);
    frame();
    @(posedge i_clk) i_branch <= '{valid: 1'b1, addr: 14'h2100};
    @(posedge i_clk) i_branch <= '0;
    @(negedge i_clk);
    check(32'(o_pc), 32'h2100);
    @(posedge i_clk) i_jump_to_start <= 1'b1;
    @(posedge i_clk) i_jump_to_start <= 1'b0;
    count_off_start(20);
    check(32'(n), 32'h0);
    foreach (cv[k]) begin
      @(posedge i_clk) i_core_out <= cv[k];
      @(posedge i_clk);
      @(negedge i_clk);
      check(32'(o_out_sample), 32'(clip(cv[k])));
    end
    @(posedge i_clk) i_core_out <= 28'h0001000;
    repeat (2) @(posedge i_clk);
    axi_write(`IDX_CORE_RUN, 32'h0);
    frame();
    @(negedge i_clk);
    check(32'(o_out_sample), 32'h1000 - 32'(`SLEW_STEP));
    frame();
    @(negedge i_clk);
    check(32'(o_out_sample), 32'h0);
    // Checksum rounds: jump held so every frame ends at once
    @(posedge i_clk);
    i_jump_to_start <= 1'b1;
    i_core_out      <= 28'h0000800;
    axi_write(`IDX_CORE_RUN, 32'h1);
    axi_write(`IDX_MP_SEL, 32'h1);
    axi_write(`IDX_ERR_MUTE, 32'h2);
    repeat (2) @(posedge i_clk);
    @(negedge i_clk);
    check(32'(o_out_sample), 32'h800);
    crc_round(~good_crc);
    expect_reg(`IDX_CKSUM_ERR, 32'h1);
    check(32'(o_multipurpose_output_pin), 32'h1);
    axi_write(`IDX_MP_SEL, 32'h0);
    @(negedge i_clk);
    check(32'(o_multipurpose_output_pin), 32'h0);
    axi_write(`IDX_MP_SEL, 32'h1);
    frame();
    @(negedge i_clk);
    check(32'(o_out_sample), 32'h0);
    axi_write(`IDX_CKSUM_EN, 32'h0);
    expect_reg(`IDX_CKSUM_ERR, 32'h0);
    check(32'(o_multipurpose_output_pin), 32'h0);
    check(32'(o_out_sample), 32'h800);
    crc_round(good_crc);
    expect_reg(`IDX_CKSUM_ERR, 32'h0);
    check(32'(o_multipurpose_output_pin), 32'h0);
    i_jump_to_start <= 1'b0;
    frame();
    repeat (5) @(posedge i_clk);
    frame();
    expect_reg(`IDX_SEQ_STAT, 32'h3);
    repeat (3600) @(posedge i_clk);
    expect_reg(`IDX_SEQ_STAT, 32'h1);
    do_reset();
    expect_reg(`IDX_SEQ_STAT, 32'h0);
    conclude();
  end
endmodule
